// ---- hdl/tia_pkg.sv ----
// Behaviour
// - In integration mode capture bits 7:2 return the six external trigger inputs.
// - In integration mode capture bits 1:0 return the two cross-trigger inputs.
// - Edge-detect builds latch rising trigger edges in integration mode until mode clears.
// - Control bit 0 selects integration mode, effective only while run bit is 0.
// - Permission status holds four 2-bit fields reading 0b10 disabled, 0b11 enabled.
// - Architecture word: architect 31:21, present bit 20 set, revision 19:16, code 15:0.
// - Configuration two bits 19:16 report level (0) or single-edge (1) trigger detection.
// - Configuration two bits 15:8 report comparator width code, zero meaning group width.
// - Alternate trace select reads 0x00, 0x10 or 0x80; other encodings read 0x00.
// - Status, architecture, three configuration words and the kind code are read-only at 0xFB8 through 0xFCC.
package tia_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int EXT_TRIG_W = 6;
  localparam int CT_TRIG_W = 2;
  localparam int TRIG_W = EXT_TRIG_W + CT_TRIG_W;
  localparam int AUTH_W = 4;

  typedef logic [ADDR_W-1:0] tia_addr_t;
  typedef logic [DATA_W-1:0] tia_word_t;

  // Register byte offsets.
  localparam tia_addr_t OFF_TRIG_CAPTURE = 12'hEF8;
  localparam tia_addr_t OFF_INTEG_CTRL = 12'hF00;
  localparam tia_addr_t OFF_AUTH_STATUS = 12'hFB8;
  localparam tia_addr_t OFF_ARCH_ID = 12'hFBC;
  localparam tia_addr_t OFF_CFG_TWO = 12'hFC0;
  localparam tia_addr_t OFF_CFG_ONE = 12'hFC4;
  localparam tia_addr_t OFF_CFG_ZERO = 12'hFC8;
  localparam tia_addr_t OFF_KIND_CODE = 12'hFCC;

  // Field positions.
  localparam int IME_BIT = 0;
  localparam int EXT_LSB = 2;
  localparam int ARCH_PRESENT_BIT = 20;
  localparam int ARCH_REV_LSB = 16;
  localparam int ARCH_ARCHITECT_LSB = 21;
  localparam int CFG2_EDGE_LSB = 16;
  localparam int CFG2_COMP_LSB = 8;
  localparam int CFG1_COUNT_LSB = 24;
  localparam int CFG1_STATES_LSB = 16;
  localparam int CFG1_GRPW_LSB = 8;

  // Field values.
  localparam logic [1:0] AUTH_DISABLED = 2'h2;
  localparam logic [1:0] AUTH_ENABLED = 2'h3;
  localparam logic [3:0] ARCH_REVISION = 4'h1;
  localparam logic [7:0] ALTERNATE_TRACE_SELECT_NONE = 8'h00;
  localparam logic [7:0] ALTERNATE_TRACE_SELECT_STATE4 = 8'h10;
  localparam logic [7:0] ALTERNATE_TRACE_SELECT_STATE7 = 8'h80;
  localparam logic [7:0] COUNT_WIDTH_BITS = 8'h20;
  localparam logic [7:0] NUM_SIG_GROUPS = 8'h0C;
  localparam int GRP_BYTE_BITS = 8;
  localparam tia_word_t ZERO_WORD = 32'h0000_0000;

endpackage

// ---- hdl/tia_sync2.sv ----
`timescale 1ns/1ps
module tia_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk, // Clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] async_in, // Signals from outside the clock domain.
  output logic [WIDTH-1:0] sync_out // Signals after two flip-flops.
);
  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1_q <= '0;
      sync_out <= '0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end
endmodule

// ---- hdl/tia_trig_capture.sv ----
`timescale 1ns/1ps
module tia_trig_capture #(
  parameter int WIDTH = 8,
  parameter int EDGE_DETECT = 0
) (
  input wire logic mclk, // Clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic enable, // Integration mode in effect.
  input wire logic [WIDTH-1:0] trig_in, // Synchronised trigger inputs.
  output logic [WIDTH-1:0] capture // Captured trigger value.
);
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] cap_d;
  wire logic [WIDTH-1:0] rise = trig_in & ~prev_q;

  generate
    if (EDGE_DETECT != 0) begin : g_edge
      // A new edge is kept even in the cycle it arrives; only leaving the mode or a reset clears.
      assign cap_d = enable ? (capture | rise) : '0;
    end else begin : g_level
      assign cap_d = enable ? trig_in : '0;
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) begin
      prev_q <= '0;
      capture <= '0;
    end else begin
      prev_q <= trig_in;
      capture <= cap_d;
    end
  end
endmodule

// ---- hdl/tia_regs.sv ----
`timescale 1ns/1ps
module tia_regs #(
  parameter int TRIG_EDGE = 0,
  parameter int SIGNAL_GROUP_WIDTH = 64,
  parameter logic [7:0] COMP_WIDTH_CODE = 8'h00,
  parameter logic [7:0] ALTERNATE_TRACE_SELECT_CODE = 8'h00,
  parameter logic [7:0] NUM_TRIG_STATES = 8'h05,
  parameter logic [10:0] ARCHITECT_CODE = 11'h155, // Arbitrary value.
  parameter logic [15:0] ARCHITECTURE_CODE = 16'h5A5A, // Arbitrary value.
  parameter logic [31:0] CFG_ZERO_VALUE = 32'h0000_0000,
  parameter logic [7:0] KIND_CODE = 8'h3C // Arbitrary value.
) (
  input wire logic mclk, // Clock, 100 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write direction.
  input wire tia_pkg::tia_addr_t paddr, // APB byte address.
  input wire tia_pkg::tia_word_t pwdata, // APB write data.
  output tia_pkg::tia_word_t prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic run_active, // Analyzer run control bit.
  input wire logic [tia_pkg::EXT_TRIG_W-1:0] external_trigger_inputs, // External trigger pins.
  input wire logic [tia_pkg::CT_TRIG_W-1:0] cross_trigger_inputs, // Cross-trigger pins.
  input wire logic invasive_debug_permit, // Invasive debug permission pin.
  input wire logic noninvasive_debug_permit, // Non-invasive debug permission pin.
  input wire logic secure_invasive_permit, // Secure invasive permission pin.
  input wire logic secure_noninvasive_permit, // Secure non-invasive permission pin.
  output logic integ_mode_active // Integration mode in effect.
);
  import tia_pkg::*;

  generate
    if (TRIG_EDGE < 0 || TRIG_EDGE > 1) begin : g_bad_edge
      $error("TRIG_EDGE must be 0 or 1");
    end
    if (SIGNAL_GROUP_WIDTH < 8 || SIGNAL_GROUP_WIDTH > 2048 || SIGNAL_GROUP_WIDTH % 8 != 0) begin : g_bad_grp
      $error("SIGNAL_GROUP_WIDTH must be a multiple of 8 up to 2048");
    end
  endgenerate

  function automatic logic word_hit(input tia_addr_t addr, input tia_addr_t off);
    return addr[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  function automatic logic [1:0] auth_field(input logic permitted);
    return permitted ? AUTH_ENABLED : AUTH_DISABLED;
  endfunction

  function automatic logic [7:0] legal_alternate_trace_select(input logic [7:0] code);
    return (code == ALTERNATE_TRACE_SELECT_STATE4 || code == ALTERNATE_TRACE_SELECT_STATE7) ? code : ALTERNATE_TRACE_SELECT_NONE;
  endfunction

  logic ime_q;
  logic ime_d;
  tia_word_t prdata_d;
  logic err_q;
  logic [TRIG_W-1:0] trig_sync;
  logic [AUTH_W-1:0] auth_sync;
  logic [TRIG_W-1:0] trig_capture;

  tia_sync2 #(
    .WIDTH(TRIG_W)
  ) u_trig_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({external_trigger_inputs, cross_trigger_inputs}),
    .sync_out(trig_sync)
  );

  tia_sync2 #(
    .WIDTH(AUTH_W)
  ) u_auth_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in({secure_noninvasive_permit, secure_invasive_permit, noninvasive_debug_permit,
               invasive_debug_permit}),
    .sync_out(auth_sync)
  );

  wire logic invasive_ok = auth_sync[0];
  wire logic noninvasive_ok = auth_sync[1];
  wire logic sec_inv_ok = auth_sync[2];
  wire logic sec_noninv_ok = auth_sync[3];

  // Integration mode only takes effect while the analyzer is stopped.
  assign integ_mode_active = ime_q & ~run_active;

  tia_trig_capture #(
    .WIDTH(TRIG_W),
    .EDGE_DETECT(TRIG_EDGE)
  ) u_capture (
    .mclk(mclk),
    .srst(srst),
    .enable(integ_mode_active),
    .trig_in(trig_sync),
    .capture(trig_capture)
  );

  wire logic setup_phase = psel & ~penable;
  wire logic access_phase = psel & penable;
  wire logic hit_capture = word_hit(paddr, OFF_TRIG_CAPTURE);
  wire logic hit_ctrl = word_hit(paddr, OFF_INTEG_CTRL);
  wire logic hit_auth = word_hit(paddr, OFF_AUTH_STATUS);
  wire logic hit_arch = word_hit(paddr, OFF_ARCH_ID);
  wire logic hit_cfg2 = word_hit(paddr, OFF_CFG_TWO);
  wire logic hit_cfg1 = word_hit(paddr, OFF_CFG_ONE);
  wire logic hit_cfg0 = word_hit(paddr, OFF_CFG_ZERO);
  wire logic hit_kind = word_hit(paddr, OFF_KIND_CODE);
  wire logic hit_any = hit_capture | hit_ctrl | hit_auth | hit_arch | hit_cfg2 | hit_cfg1 | hit_cfg0 | hit_kind;

  // External triggers in the upper six bits, cross triggers in the lower two.
  wire tia_word_t capture_word = {{(DATA_W - TRIG_W){1'b0}}, trig_capture};
  wire tia_word_t ctrl_word = {{(DATA_W - 1){1'b0}}, ime_q};
  wire tia_word_t auth_word = {24'h00_0000,
                               auth_field((invasive_ok | noninvasive_ok) & (sec_inv_ok | sec_noninv_ok)),
                               auth_field(invasive_ok & sec_inv_ok),
                               auth_field(invasive_ok | noninvasive_ok),
                               auth_field(invasive_ok)};
  wire tia_word_t arch_word = {ARCHITECT_CODE, 1'b1, ARCH_REVISION, ARCHITECTURE_CODE};
  wire logic [3:0] edge_style = TRIG_EDGE[3:0];
  wire tia_word_t cfg2_word = {12'h000, edge_style, COMP_WIDTH_CODE, legal_alternate_trace_select(ALTERNATE_TRACE_SELECT_CODE)};
  localparam int GRP_CODE = SIGNAL_GROUP_WIDTH / GRP_BYTE_BITS - 1;
  wire logic [7:0] grp_code = GRP_CODE[7:0];
  wire tia_word_t cfg1_word = {COUNT_WIDTH_BITS, NUM_TRIG_STATES, grp_code, NUM_SIG_GROUPS};
  wire tia_word_t kind_word = {24'h00_0000, KIND_CODE};

  assign prdata_d = ({DATA_W{hit_capture}} & capture_word)
                  | ({DATA_W{hit_ctrl}} & ctrl_word)
                  | ({DATA_W{hit_auth}} & auth_word)
                  | ({DATA_W{hit_arch}} & arch_word)
                  | ({DATA_W{hit_cfg2}} & cfg2_word)
                  | ({DATA_W{hit_cfg1}} & cfg1_word)
                  | ({DATA_W{hit_cfg0}} & CFG_ZERO_VALUE)
                  | ({DATA_W{hit_kind}} & kind_word);

  // Only the control word is writable; every other write falls through with no effect.
  assign ime_d = (access_phase & pwrite & hit_ctrl) ? pwdata[IME_BIT] : ime_q;

  // Zero-wait slave: data and error are prepared in setup, presented in access.
  assign pready = 1'b1;
  assign pslverr = access_phase & err_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ime_q <= 1'b0;
      prdata <= ZERO_WORD;
      err_q <= 1'b0;
    end else begin
      ime_q <= ime_d;
      if (setup_phase) begin
        prdata <= pwrite ? ZERO_WORD : prdata_d;
        err_q <= ~hit_any;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_mode_enable: assert property (access_phase && pwrite && hit_ctrl && pwdata[IME_BIT] && !run_active
                                  ##1 !run_active |-> integ_mode_active)
    else $error("integration mode not entered after enable write");
  a_mode_run_block: assert property (run_active |-> !integ_mode_active)
    else $error("integration mode active while running");
  a_cap_map: assert property (setup_phase && !pwrite && hit_capture
                              |=> prdata == {24'h00_0000, $past(trig_capture)})
    else $error("capture read does not return trigger bits");
  a_cap_cleared: assert property (!integ_mode_active ##1 !integ_mode_active |-> trig_capture == '0)
    else $error("capture not cleared outside integration mode");
  a_edge_held: assert property (TRIG_EDGE == 1 && integ_mode_active ##1 integ_mode_active
                                |-> (trig_capture & $past(trig_capture)) == $past(trig_capture))
    else $error("latched trigger edge lost in integration mode");
  a_auth_fields: assert property (setup_phase && !pwrite && hit_auth
                                  |=> prdata[7] && prdata[5] && prdata[3] && prdata[1] && prdata[31:8] == 24'h0)
    else $error("permission field outside 0b10/0b11");
  a_arch_present: assert property (setup_phase && !pwrite && hit_arch
                                   |=> prdata[ARCH_PRESENT_BIT] && prdata[19:16] == ARCH_REVISION)
    else $error("architecture word present or revision wrong");
  a_cfg2_fields: assert property (setup_phase && !pwrite && hit_cfg2
                                  |=> prdata[7:0] inside {8'h00, 8'h10, 8'h80} && prdata[31:20] == 12'h0
                                  && prdata[19:16] == edge_style && prdata[15:8] == COMP_WIDTH_CODE)
    else $error("configuration two field wrong");
  a_ro_ignored: assert property (access_phase && pwrite && !hit_ctrl |=> $stable(ime_q))
    else $error("write to read-only word changed state");
  a_unmapped_err: assert property (setup_phase && !hit_any ##1 access_phase |-> pslverr && pready)
    else $error("unmapped access not flagged");

  c_mode_on: cover property (access_phase && pwrite && hit_ctrl && pwdata[IME_BIT] ##1 integ_mode_active);
  c_cap_seen: cover property (integ_mode_active && trig_capture != '0);
  c_cap_read: cover property (setup_phase && !pwrite && hit_capture && trig_capture != '0);
  c_unmapped: cover property (access_phase && pslverr);
endmodule

// ---- bench/tia_trig_src.sv ----
`timescale 1ns/1ps
module tia_trig_src (
  input wire logic mclk, // Clock.
  input wire logic slow, // Adds one cycle before new levels appear.
  input wire logic [7:0] want, // Requested levels, external 7:2, cross-trigger 1:0.
  output logic [5:0] external_trigger_inputs, // External trigger pins.
  output logic [1:0] cross_trigger_inputs // Cross-trigger pins.
);
  logic [7:0] stage_q = 8'h00;
  logic [7:0] pins_q = 8'h00;
  // Levels move only when the request changes, so they hold steady across a register read.
  always @(posedge mclk) begin
    stage_q <= want;
    pins_q <= slow ? stage_q : want;
  end
  assign external_trigger_inputs = pins_q[7:2];
  assign cross_trigger_inputs = pins_q[1:0];
endmodule

// ---- bench/trace_integ_auth_id_regs_bench.sv ----
`timescale 1ns/1ps
module trace_integ_auth_id_regs_bench;
  import tia_pkg::*;
  localparam logic [7:0] COMP_CODE = 8'h0F;
  localparam logic [7:0] ALT_CODE = 8'h10;
  localparam logic [10:0] ARCHITECT = 11'h155; // Arbitrary value.
  localparam logic [15:0] ARCH_CODE = 16'h5A5A; // Arbitrary value.
  localparam logic [7:0] KIND = 8'h3C; // Arbitrary value.
  localparam tia_addr_t ID_ADDR [6] = '{OFF_AUTH_STATUS, OFF_ARCH_ID, OFF_CFG_TWO, OFF_CFG_ONE,
    OFF_CFG_ZERO, OFF_KIND_CODE};
  localparam tia_word_t ID_EXP [6] = '{32'h0000_00AA, {ARCHITECT, 1'b1, ARCH_REVISION, ARCH_CODE},
    {12'h000, 4'h0, COMP_CODE, ALT_CODE}, 32'h2005_070C, 32'h0000_0000, {24'h000000, KIND}};
  localparam logic [7:0] PATS [4] = '{8'hA5, 8'h5A, 8'h81, 8'h7E};
  // Second build: edge-detecting triggers, a reserved trace-select code and wider signal groups.
  localparam logic [7:0] BAD_ALT_CODE = 8'h33;
  localparam logic [7:0] EDGE_STATES = 8'h08;
  localparam int EDGE_GRP_W = 128;
  localparam tia_word_t ID_EXP_E [6] = '{32'h0000_00AA, {ARCHITECT, 1'b1, ARCH_REVISION, ARCH_CODE},
    32'h0001_0000, 32'h2008_0F0C, 32'h0000_0000, {24'h000000, KIND}};
  tia_word_t prdata_e;
  tia_word_t rd_e;
  logic pready_e;
  logic pslverr_e;
  logic err_e;
  logic integ_mode_active_e;
  logic [7:0] acc = 8'h00;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  tia_addr_t paddr = '0;
  tia_word_t pwdata = '0;
  tia_word_t prdata;
  tia_word_t rd;
  logic pready;
  logic pslverr;
  logic err;
  logic run_active = 1'b0;
  logic integ_mode_active;
  logic slow = 1'b0;
  logic [3:0] permits = 4'h0;
  logic [7:0] want = 8'h00;
  logic [5:0] ext_pins;
  logic [1:0] ct_pins;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  always #5 mclk = ~mclk;

  tia_regs #(.COMP_WIDTH_CODE(COMP_CODE), .ALTERNATE_TRACE_SELECT_CODE(ALT_CODE), .ARCHITECT_CODE(ARCHITECT),
    .ARCHITECTURE_CODE(ARCH_CODE), .KIND_CODE(KIND)) dut (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_active(run_active),
    .external_trigger_inputs(ext_pins), .cross_trigger_inputs(ct_pins),
    .invasive_debug_permit(permits[3]), .noninvasive_debug_permit(permits[2]),
    .secure_invasive_permit(permits[1]), .secure_noninvasive_permit(permits[0]),
    .integ_mode_active(integ_mode_active));

  tia_regs #(.TRIG_EDGE(1), .SIGNAL_GROUP_WIDTH(EDGE_GRP_W), .COMP_WIDTH_CODE(8'h00), .ALTERNATE_TRACE_SELECT_CODE(BAD_ALT_CODE),
    .NUM_TRIG_STATES(EDGE_STATES), .ARCHITECT_CODE(ARCHITECT), .ARCHITECTURE_CODE(ARCH_CODE),
    .KIND_CODE(KIND)) dut_edge (
    .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_e), .pready(pready_e), .pslverr(pslverr_e), .run_active(run_active),
    .external_trigger_inputs(ext_pins), .cross_trigger_inputs(ct_pins),
    .invasive_debug_permit(permits[3]), .noninvasive_debug_permit(permits[2]),
    .secure_invasive_permit(permits[1]), .secure_noninvasive_permit(permits[0]),
    .integ_mode_active(integ_mode_active_e));

  tia_trig_src src (.mclk(mclk), .slow(slow), .want(want), .external_trigger_inputs(ext_pins),
    .cross_trigger_inputs(ct_pins));

  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input tia_word_t seen, input tia_word_t exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input tia_addr_t a, input tia_word_t wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    rd_e = prdata_e;
    err_e = pslverr_e;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", {31'h0, pready}, 32'h1);
    check("edge pready", {31'h0, pready_e}, 32'h1);
  endtask

  function automatic tia_word_t auth_exp(input logic [3:0] p);
    return {24'h0, 1'b1, (p[3] | p[2]) & (p[1] | p[0]), 1'b1, p[3] & p[1], 1'b1, p[3] | p[2], 1'b1, p[3]};
  endfunction

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, OFF_INTEG_CTRL, '0);
    check("ctrl reset", rd, ZERO_WORD);
    check("edge ctrl reset", rd_e, ZERO_WORD);
    apb(1'b0, OFF_TRIG_CAPTURE, '0);
    check("capture reset", rd, ZERO_WORD);
    check("edge capture reset", rd_e, ZERO_WORD);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ID_ADDR[i], '0);
      check("id word", rd, ID_EXP[i]);
      check("edge id word", rd_e, ID_EXP_E[i]);
      check("id err", {31'h0, err}, 32'h0);
      apb(1'b1, ID_ADDR[i], 32'hFFFF_FFFF);
      apb(1'b0, ID_ADDR[i], '0);
      check("id after write", rd, ID_EXP[i]);
      check("edge id after write", rd_e, ID_EXP_E[i]);
    end
    for (int i = 0; i < 16; i++) begin
      permits <= i[3:0];
      repeat (4) @(posedge mclk);
      apb(1'b0, OFF_AUTH_STATUS, '0);
      check("permission status", rd, auth_exp(i[3:0]));
      check("edge permission status", rd_e, auth_exp(i[3:0]));
    end
    apb(1'b0, 12'h004, '0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, ZERO_WORD);
    check("edge unmapped err", {31'h0, err_e}, 32'h1);
    // This build has no trace-bus output, so the mode is enabled with no prior setup.
    apb(1'b1, OFF_INTEG_CTRL, 32'h0000_0001);
    apb(1'b0, OFF_INTEG_CTRL, '0);
    check("ctrl set", rd, 32'h0000_0001);
    check("mode on", {31'h0, integ_mode_active}, 32'h1);
    check("edge mode on", {31'h0, integ_mode_active_e}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      want <= PATS[k];
      slow <= k[0];
      acc = acc | PATS[k];
      repeat (6) @(posedge mclk);
      apb(1'b0, OFF_TRIG_CAPTURE, '0);
      check("capture", rd, {24'h0, PATS[k]});
      check("edge capture", rd_e, {24'h0, acc});
    end
    // Falling pins leave the edge build's latched bits in place.
    want <= 8'h00;
    repeat (6) @(posedge mclk);
    apb(1'b0, OFF_TRIG_CAPTURE, '0);
    check("capture low", rd, ZERO_WORD);
    check("edge capture held", rd_e, {24'h0, acc});
    // No register access while running.
    @(posedge mclk);
    run_active <= 1'b1;
    @(posedge mclk);
    #1;
    check("mode while running", {31'h0, integ_mode_active}, 32'h0);
    check("edge mode while running", {31'h0, integ_mode_active_e}, 32'h0);
    @(posedge mclk);
    run_active <= 1'b0;
    @(posedge mclk);
    #1;
    check("mode after run", {31'h0, integ_mode_active}, 32'h1);
    check("edge mode after run", {31'h0, integ_mode_active_e}, 32'h1);
    apb(1'b0, OFF_TRIG_CAPTURE, '0);
    check("edge capture after run", rd_e, ZERO_WORD);
    apb(1'b1, OFF_INTEG_CTRL, ZERO_WORD);
    apb(1'b0, OFF_TRIG_CAPTURE, '0);
    check("capture mode off", rd, ZERO_WORD);
    check("edge capture mode off", rd_e, ZERO_WORD);
    check("mode off", {31'h0, integ_mode_active}, 32'h0);
    // A reset while the mode is enabled must clear the mode enable again.
    apb(1'b1, OFF_INTEG_CTRL, 32'h0000_0001);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, OFF_INTEG_CTRL, '0);
    check("ctrl after reset", rd, ZERO_WORD);
    check("edge ctrl after reset", rd_e, ZERO_WORD);
    check("mode after reset", {31'h0, integ_mode_active}, 32'h0);
    end_of_test();
  end
endmodule
